// >>> slp_pkg.sv
/*
  slp_pkg: register map, field layout, reset values and codes for the
  loss-of-lock flag and phase offset block.
  assumes: byte-wide register access as decoded by slp_top.
*/
package slp_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses of the serial port map)
  // ----------------------------------------------------------------
  localparam logic [7:0] SLP_STATUS_ADDR  = 8'hb9;
  localparam logic [7:0] SLP_CLEAR_ADDR   = 8'hba;
  localparam logic [7:0] SLP_DIVC_LO_ADDR = 8'hbf;
  localparam logic [7:0] SLP_DIVC_HI_ADDR = 8'hc0;
  localparam logic [7:0] SLP_DIVD_LO_ADDR = 8'hc1;
  localparam logic [7:0] SLP_DIVD_HI_ADDR = 8'hc2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  SLP_STATUS_RST = 8'h00;
  localparam logic [7:0]  SLP_CLEAR_RST  = 8'h00;
  localparam logic [15:0] SLP_PHASE_RST  = 16'h0000;
  localparam logic [1:0]  SLP_FLAG_SET   = 2'h3;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int SLP_NUM_PLL      = 2;
  localparam int SLP_PERIOD_W     = 13;
  localparam int SLP_PERIOD_MSB   = 12;
  localparam int SLP_EIGHTH_LSB   = 13;
  localparam int SLP_EIGHTH_MSB   = 15;

  // eighth-turn codes, degrees = code meaning
  typedef enum logic [2:0] {
    SLP_Q_NONE   = 3'h0,
    SLP_Q_M45    = 3'h1,
    SLP_Q_M90    = 3'h2,
    SLP_Q_M135   = 3'h3,
    SLP_Q_180    = 3'h4,
    SLP_Q_P135   = 3'h5,
    SLP_Q_P90    = 3'h6,
    SLP_Q_P45    = 3'h7
  } slp_eighth_t;

endpackage

// >>> slp_lock_if.sv
/*
  slp_lock_if: carries lock flags and clear levels between the register
  file and the sticky flag module.
  assumes: one clock domain, driven by slp_top.
*/
`timescale 1ns/100ps
interface slp_lock_if;
  logic [1:0] unlock_event;
  logic [1:0] clear_level;
  logic [1:0] sticky;

  modport regs
  (
    output unlock_event,
    output clear_level,
    input  sticky
  );
  modport flags
  (
    input  unlock_event,
    input  clear_level,
    output sticky
  );
endinterface

// >>> slp_sticky_flags.sv
/*
  slp_sticky_flags: one sticky loss-of-lock flag per synthesizer.
  assumes: unlock events already synchronised to clk_in.
*/
`timescale 1ns/100ps
module slp_sticky_flags
  import slp_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  slp_lock_if.flags lk
);

  logic [1:0] flag;
  logic [1:0] next_flag;

  // ----------------------------------------------------------------
  // per synthesizer flag
  // ----------------------------------------------------------------
  // the clear is a level and wins over a new loss while held high;
  // the host must drop it to rearm the flag.
  genvar gi;
  generate
    for (gi = 0; gi < SLP_NUM_PLL; gi++)
    begin : g_flag
      assign next_flag[gi] = lk.clear_level[gi] ? 1'b0 :
                             (flag[gi] | lk.unlock_event[gi]);
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      flag <= SLP_FLAG_SET;
    else if (ce_in)
      flag <= next_flag;
  end

  assign lk.sticky = flag;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  flag_holds_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && flag[0] && !lk.clear_level[0] |=> flag[0])
    else $error("flag 0 dropped without clear");
  flag_clear_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && lk.clear_level[1] |=> !flag[1])
    else $error("flag 1 survived clear");
  flag_set_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && lk.unlock_event[1] && !lk.clear_level[1] |=> flag[1])
    else $error("flag 1 missed unlock");
  flag_reset_a : assert property (
    @(posedge clk_in)
    srst_in |=> flag == SLP_FLAG_SET)
    else $error("flags not set after reset");
endmodule

// >>> slp_top.sv
/*
  slp_top: loss-of-lock sticky status, clear register and synthesizer 0
  post divider C/D phase offset registers, byte access.
  assumes: host writes/reads one byte per cycle via a decoded strobe
  port; lock inputs come from synthesizer clock domains.
*/
// Contract
// - pll 0 unlock sets status bit 0, held until cleared.
// - both sticky flags set at power-up and every reset.
// - pll 1 unlock behaves the same in status bit 1.
// - clear bit high keeps the matching sticky flag cleared.
// - divider C shifted by signed 13-bit period count, zero none.
// - negative count delays, positive count advances, per period.
// - bits 15:13 pick divider C eighth-turn shift code.
// - divider D gets same signed 13-bit period count.
`timescale 1ns/100ps
module slp_top
  import slp_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              ce_in,
  input  wire logic [7:0]        addr_in,
  input  wire logic              wr_en_in,
  input  wire logic              rd_en_in,
  input  wire logic [7:0]        wdata_in,
  output logic      [7:0]        rdata_out,
  output logic                   rvalid_out,
  input  wire logic              pll0_unlock_in,
  input  wire logic              pll1_unlock_in,
  output logic      [1:0]        unlock_sticky_out,
  output logic signed [12:0]     pll0_div_c_period_offset_out,
  output logic      [2:0]        pll0_div_c_eighth_turn_out,
  output logic signed [12:0]     pll0_div_d_period_offset_out,
  output logic                   pll0_div_c_delay_out,
  output logic                   pll0_div_c_advance_out,
  output logic                   pll0_div_d_delay_out,
  output logic                   pll0_div_d_advance_out
);

  // ----------------------------------------------------------------
  // lock input synchronisers
  // ----------------------------------------------------------------
  // unlock pulses come from another clock; two stages before use.
  logic [1:0] unlock_meta;
  logic [1:0] unlock_sync;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      unlock_meta <= 2'h0;
      unlock_sync <= 2'h0;
    end
    else if (ce_in)
    begin
      unlock_meta <= {pll1_unlock_in, pll0_unlock_in};
      unlock_sync <= unlock_meta;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  clear_reg;
  logic [15:0] divc_reg;
  logic [15:0] divd_reg;

  wire hit_clear   = (addr_in == SLP_CLEAR_ADDR);
  wire hit_divc_lo = (addr_in == SLP_DIVC_LO_ADDR);
  wire hit_divc_hi = (addr_in == SLP_DIVC_HI_ADDR);
  wire hit_divd_lo = (addr_in == SLP_DIVD_LO_ADDR);
  wire hit_divd_hi = (addr_in == SLP_DIVD_HI_ADDR);
  wire hit_status  = (addr_in == SLP_STATUS_ADDR);
  wire hit_any     = hit_status | hit_clear | hit_divc_lo | hit_divc_hi |
                     hit_divd_lo | hit_divd_hi;

  wire wr_go = ce_in && wr_en_in;

  // reserved clear bits are kept at default; only bits 1:0 store.
  wire [7:0] next_clear = {6'h00, wdata_in[1:0]};

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      clear_reg <= SLP_CLEAR_RST;
      divc_reg  <= SLP_PHASE_RST;
      divd_reg  <= SLP_PHASE_RST;
    end
    else if (wr_go)
    begin
      if (hit_clear)
        clear_reg <= next_clear;
      if (hit_divc_lo)
        divc_reg[7:0] <= wdata_in;
      if (hit_divc_hi)
        divc_reg[15:8] <= wdata_in;
      if (hit_divd_lo)
        divd_reg[7:0] <= wdata_in;
      if (hit_divd_hi)
        divd_reg[15:8] <= wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  slp_lock_if lk ();

  assign lk.unlock_event = unlock_sync;
  assign lk.clear_level  = clear_reg[1:0];

  slp_sticky_flags slp_sticky_flags_i
  (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .ce_in   (ce_in),
    .lk      (lk.flags)
  );

  wire [7:0] status_val = {6'h00, lk.sticky};

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // reads are side-effect free; unmapped addresses read zero.
  wire [7:0] rd_mux =
    hit_status  ? status_val     :
    hit_clear   ? clear_reg      :
    hit_divc_lo ? divc_reg[7:0]  :
    hit_divc_hi ? divc_reg[15:8] :
    hit_divd_lo ? divd_reg[7:0]  :
    hit_divd_hi ? divd_reg[15:8] : 8'h00;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rdata_out  <= 8'h00;
      rvalid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rvalid_out <= rd_en_in;
      if (rd_en_in)
        rdata_out <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // phase control outputs
  // ----------------------------------------------------------------
  // fields come straight from flops; the divider applies them.
  assign unlock_sticky_out            = lk.sticky;
  assign pll0_div_c_period_offset_out =
    signed'(divc_reg[SLP_PERIOD_MSB:0]);
  assign pll0_div_c_eighth_turn_out   =
    divc_reg[SLP_EIGHTH_MSB:SLP_EIGHTH_LSB];
  assign pll0_div_d_period_offset_out =
    signed'(divd_reg[SLP_PERIOD_MSB:0]);

  // sign picks direction: negative delays, positive advances.
  assign pll0_div_c_delay_out   = divc_reg[SLP_PERIOD_MSB];
  assign pll0_div_c_advance_out = !divc_reg[SLP_PERIOD_MSB] &&
                                  (divc_reg[SLP_PERIOD_MSB:0] != 13'h0000);
  assign pll0_div_d_delay_out   = divd_reg[SLP_PERIOD_MSB];
  assign pll0_div_d_advance_out = !divd_reg[SLP_PERIOD_MSB] &&
                                  (divd_reg[SLP_PERIOD_MSB:0] != 13'h0000);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  read_keeps_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && rd_en_in && hit_status && !(|clear_reg[1:0]) &&
    !(|unlock_sync) |=> lk.sticky == $past(lk.sticky))
    else $error("status read changed flags");
  read_data_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && rd_en_in && hit_status |=> rvalid_out &&
    rdata_out == {6'h00, $past(lk.sticky)})
    else $error("status read data wrong");
  clear_hold_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && clear_reg[0] ##1 ce_in && clear_reg[0] |-> !lk.sticky[0])
    else $error("clear level did not hold flag 0 low");
  divc_write_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_go && hit_divc_hi |=>
    pll0_div_c_eighth_turn_out == $past(wdata_in[7:5]))
    else $error("eighth turn field not written");
  divc_sign_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    pll0_div_c_period_offset_out < 0 |-> pll0_div_c_delay_out &&
    !pll0_div_c_advance_out)
    else $error("negative offset not a delay");
  divc_zero_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    pll0_div_c_period_offset_out == 0 |->
    !pll0_div_c_delay_out && !pll0_div_c_advance_out)
    else $error("zero offset not neutral");
  divd_write_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_go && hit_divd_lo |=>
    pll0_div_d_period_offset_out[7:0] == $past(wdata_in))
    else $error("divider d offset not written");
  unlock_path_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && pll1_unlock_in && !clear_reg[1] ##1 ce_in && !clear_reg[1]
    ##1 ce_in && !clear_reg[1] |=> unlock_sticky_out[1])
    else $error("pll 1 unlock not reported");
  unlock0_path_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && pll0_unlock_in && !clear_reg[0] ##1 ce_in && !clear_reg[0]
    ##1 ce_in && !clear_reg[0] |=> unlock_sticky_out[0])
    else $error("pll 0 unlock not reported");
  clear1_hold_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && clear_reg[1] ##1 ce_in && clear_reg[1] |-> !lk.sticky[1])
    else $error("clear level did not hold flag 1 low");
  sync_reset_a : assert property (
    @(posedge clk_in)
    srst_in |=> unlock_sync == 2'h0)
    else $error("stale unlock survived reset");

  // ----------------------------------------------------------------
  // checks: register writes and offset decode
  // ----------------------------------------------------------------
  reset_regs_a : assert property (
    @(posedge clk_in)
    srst_in |=> divc_reg == SLP_PHASE_RST && divd_reg == SLP_PHASE_RST &&
    clear_reg == SLP_CLEAR_RST)
    else $error("registers not at reset value");
  clear_write_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_go && hit_clear |=> clear_reg == {6'h00, $past(wdata_in[1:0])})
    else $error("clear register not written");
  status_ignore_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_go && hit_status |=> clear_reg == $past(clear_reg) &&
    divc_reg == $past(divc_reg) && divd_reg == $past(divd_reg))
    else $error("status write changed a register");
  divc_low_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_go && hit_divc_lo |=>
    pll0_div_c_period_offset_out[7:0] == $past(wdata_in))
    else $error("divider c low offset not written");
  divc_period_hi_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_go && hit_divc_hi |=>
    pll0_div_c_period_offset_out[12:8] == $past(wdata_in[4:0]))
    else $error("divider c high offset not written");
  divd_high_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_go && hit_divd_hi |=>
    pll0_div_d_period_offset_out[12:8] == $past(wdata_in[4:0]))
    else $error("divider d high offset not written");
  divc_advance_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    pll0_div_c_period_offset_out > 0 |-> pll0_div_c_advance_out &&
    !pll0_div_c_delay_out)
    else $error("positive offset not an advance");
  divd_sign_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    pll0_div_d_period_offset_out < 0 |-> pll0_div_d_delay_out &&
    !pll0_div_d_advance_out)
    else $error("divider d negative offset not a delay");
  divd_advance_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    pll0_div_d_period_offset_out > 0 |-> pll0_div_d_advance_out &&
    !pll0_div_d_delay_out)
    else $error("divider d positive offset not an advance");
  divd_zero_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    pll0_div_d_period_offset_out == 0 |->
    !pll0_div_d_delay_out && !pll0_div_d_advance_out)
    else $error("divider d zero offset not neutral");

  // ----------------------------------------------------------------
  // checks: read path and clock enable
  // ----------------------------------------------------------------
  read_pulse_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && !rd_en_in |=> !rvalid_out)
    else $error("read valid without a read");
  read_hold_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && !rd_en_in |=> rdata_out == $past(rdata_out))
    else $error("read data moved without a read");
  unmapped_read_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && rd_en_in && !hit_any |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  clear_read_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ce_in && rd_en_in && hit_clear |=> rdata_out == $past(clear_reg))
    else $error("clear register read back wrong");
  // a low enable holds every flop, the read pipe included
  freeze_flags_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    !ce_in |=> lk.sticky == $past(lk.sticky))
    else $error("flags moved while disabled");
  freeze_phase_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    !ce_in |=> divc_reg == $past(divc_reg) &&
    divd_reg == $past(divd_reg))
    else $error("offsets moved while disabled");
  freeze_clear_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    !ce_in |=> clear_reg == $past(clear_reg))
    else $error("clear register moved while disabled");
  freeze_read_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    !ce_in |=> rvalid_out == $past(rvalid_out) &&
    rdata_out == $past(rdata_out))
    else $error("read pipe moved while disabled");
endmodule

// >>> slp_host_model.sv
/*
  slp_host_model: host side of the byte register port, with access tasks.
  assumes: shares clk_in with slp_top; one request at a time.
*/
`timescale 1ns/100ps
module slp_host_model
(
  input  wire logic       clk_in,
  output logic      [7:0] addr_out,
  output logic            wr_en_out,
  output logic            rd_en_out,
  output logic      [7:0] wdata_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in
);
  initial
  begin
    addr_out  = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    wdata_out = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_en_out <= 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // released data inverted so a stale byte never looks valid
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk_in);
    addr_out  <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    #1;
    d = rdata_in;
    v = rvalid_in;
  endtask

  // clear, rearm, read back: a survivor is a real loss of lock
  task automatic clr(input logic [1:0] m, output logic [1:0] lost);
    logic [7:0] s;
    logic       v;
    wr(8'hba, {6'h00, m});
    wr(8'hba, 8'h00);
    rd(8'hb9, s, v);
    lost = s[1:0] & m;
  endtask
endmodule

// >>> test_synth_lock_flag_phase_shift.sv
/*
  test_synth_lock_flag_phase_shift: self-checking bench for slp_top.
  assumes: slp_host_model drives the register port.
*/
`timescale 1ns/100ps
module test_synth_lock_flag_phase_shift
  import slp_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [1:0] unl = 2'h0;
  logic [7:0] addr, wdata, rdata;
  logic wr_en, rd_en, rvalid, c_dly, c_adv, d_dly, d_adv;
  logic [1:0] sticky;
  logic [2:0] c_q;
  logic signed [12:0] c_off, d_off;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #5 clk_in = ~clk_in;

  slp_host_model slp_host_model_i (.clk_in(clk_in), .addr_out(addr),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .wdata_out(wdata),
    .rdata_in(rdata), .rvalid_in(rvalid));

  slp_top slp_top_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .addr_in(addr), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid),
    .pll0_unlock_in(unl[0]), .pll1_unlock_in(unl[1]),
    .unlock_sticky_out(sticky), .pll0_div_c_period_offset_out(c_off),
    .pll0_div_c_eighth_turn_out(c_q), .pll0_div_d_period_offset_out(d_off),
    .pll0_div_c_delay_out(c_dly), .pll0_div_c_advance_out(c_adv),
    .pll0_div_d_delay_out(d_dly), .pll0_div_d_advance_out(d_adv));

  task automatic stop_test;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // unlock held two cycles so the synchroniser surely sees it
  task automatic pulse(input logic [1:0] m);
    @(posedge clk_in);
    unl <= m;
    repeat (2) @(posedge clk_in);
    unl <= 2'h0;
    repeat (5) @(posedge clk_in);
    #1;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    logic       v;
    chk(sticky, 2'h3);
    slp_host_model_i.rd(SLP_STATUS_ADDR, d, v);
    chk(v, 1'b1);
    chk(d, 8'h03);
    slp_host_model_i.wr(SLP_STATUS_ADDR, 8'h00);
    chk(sticky, 2'h3);
    slp_host_model_i.rd(8'h00, d, v);
    chk(d, 8'h00);
    slp_host_model_i.rd(SLP_DIVC_HI_ADDR, d, v);
    chk(d, 8'h00);
  endtask

  task automatic t_clear;
    logic [7:0] d;
    logic       v;
    logic [1:0] lost;
    slp_host_model_i.wr(SLP_CLEAR_ADDR, 8'h03);
    pulse(2'h1);
    chk(sticky, 2'h0);
    slp_host_model_i.clr(2'h3, lost);
    chk(lost, 2'h0);
    slp_host_model_i.rd(SLP_STATUS_ADDR, d, v);
    chk(d, 8'h00);
    pulse(2'h1);
    chk(sticky, 2'h1);
    @(posedge clk_in);
    unl <= 2'h1;
    slp_host_model_i.clr(2'h1, lost);
    chk(lost, 2'h1);
    @(posedge clk_in);
    unl <= 2'h0;
    repeat (4) @(posedge clk_in);
    slp_host_model_i.clr(2'h1, lost);
    chk(lost, 2'h0);
    pulse(2'h2);
    chk(sticky, 2'h2);
    @(posedge clk_in);
    srst_in <= 1'b1;
    @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    chk(sticky, 2'h3);
  endtask

  task automatic t_phase;
    logic signed [12:0] off [8] = '{0, 1, -1, 4095, -4096, 2, -2, 100};
    logic signed [12:0] o, n;
    logic [7:0] d;
    logic       v;
    for (int i = 0; i < 8; i++)
    begin
      o = off[i];
      n = -o;
      slp_host_model_i.wr(SLP_DIVC_LO_ADDR, o[7:0]);
      slp_host_model_i.wr(SLP_DIVC_HI_ADDR, {i[2:0], o[12:8]});
      slp_host_model_i.wr(SLP_DIVD_LO_ADDR, n[7:0]);
      slp_host_model_i.wr(SLP_DIVD_HI_ADDR, {3'h0, n[12:8]});
      @(posedge clk_in);
      #1;
      chk(c_off, o);
      chk(c_q, i[2:0]);
      chk({c_dly, c_adv}, {o < 0, o > 0});
      chk(d_off, n);
      chk({d_dly, d_adv}, {n < 0, n > 0});
      slp_host_model_i.rd(SLP_DIVC_HI_ADDR, d, v);
      chk(d, {i[2:0], o[12:8]});
    end
  endtask

  // enable low: writes, reads and flags all hold
  task automatic t_freeze;
    logic [7:0] d;
    logic       v;
    @(posedge clk_in);
    ce_in <= 1'b0;
    slp_host_model_i.wr(SLP_DIVD_HI_ADDR, 8'h00);
    slp_host_model_i.wr(SLP_CLEAR_ADDR, 8'h03);
    slp_host_model_i.rd(SLP_STATUS_ADDR, d, v);
    chk({v, d}, {1'b0, 8'he0});
    @(posedge clk_in);
    ce_in <= 1'b1;
    slp_host_model_i.rd(SLP_DIVD_LO_ADDR, d, v);
    chk({v, d}, {1'b1, 8'h9c});
    chk(d_off, -13'sd100);
    chk(sticky, 2'h3);
  endtask

  // ------------------------------------------------------------------
  // run and hang guard
  // ------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      stop_test;
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset;
    t_clear;
    t_phase;
    t_freeze;
    stop_test;
  end
endmodule
